// *** hrc_dev.sv ***
// device end: decodes register and nvm instructions from the serial link
`timescale 1ns/100ps
module hrc_dev
  import hrc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  hrc_spi_if.dev           spi,
  output logic             exc_pulse,
  output logic [31:0]      cfg0
);
  logic              sck_s1, sck_s2, sck_d;
  logic              nss_s1, nss_s2, nss_d;
  logic              mosi_s1, mosi_s2;
  logic              rise, fall, fstart, fend;
  logic [31:0]       regs_reg  [REG_COUNT];
  logic [31:0]       regs_next [REG_COUNT];
  logic [7:0]        eep_reg   [EE_SIZE];
  logic [7:0]        eep_next  [EE_SIZE];
  logic [7:0]        list_reg  [RDM_MAX];
  logic [7:0]        list_next [RDM_MAX];
  logic [7:0]        shin_reg, shin_next, shout_reg, shout_next;
  logic [2:0]        bit_reg, bit_next, obit_reg, obit_next, sub_reg, sub_next;
  logic [8:0]        pos_reg, pos_next, obyte_reg, obyte_next;
  logic [5:0]        ent_reg, ent_next;
  logic [4:0]        nlist_reg, nlist_next;
  logic [7:0]        op_reg, op_next, addr_reg, addr_next, act_reg, act_next;
  logic [7:0]        ees_reg, ees_next, eel_reg, eel_next;
  logic [31:0]       val_reg, val_next;
  logic              ferr_reg, ferr_next, pend_reg, pend_next, ree_reg, ree_next;
  logic              ract_reg, ract_next, busy_reg, busy_next, irq_reg, irq_next;
  logic              exc_reg, exc_next;
  logic [ERR_W-1:0]  err;
  logic [7:0]        b;
  logic [8:0]        ea;

  function automatic logic addr_ok(input logic [7:0] a);
    return a < REG_LIMIT; // R2
  endfunction

  function automatic logic [31:0] merge(input logic [7:0] act, input logic [31:0] old,
                                        input logic [31:0] v);
    unique case (act)
      ACT_OR:  return old | v; // R3 R6
      ACT_AND: return old & v; // R4 R6
      default: return v; // R1 R6
    endcase
  endfunction

  // answer byte k of the pending read, zero past its end
  function automatic logic [7:0] resp_byte(input logic [8:0] k);
    logic [8:0]  ra;
    logic [31:0] w;
    ra = 9'({1'b0, ees_reg} + k);
    w = 32'h0000_0000;
    resp_byte = 8'h00;
    if (ree_reg) begin
      if (k < {1'b0, eel_reg}) begin
        resp_byte = eep_reg[ra[7:0]]; // R13
      end
    end else if (k < {2'b00, nlist_reg, 2'b00}) begin
      w = regs_reg[list_reg[k[6:2]][REG_AW-1:0]];
      resp_byte = w[{k[1:0], 3'b000} +: 8]; // R8 R10
    end
  endfunction

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sck_s1  <= 1'b0;
      sck_s2  <= 1'b0;
      sck_d   <= 1'b0;
      nss_s1  <= 1'b1;
      nss_s2  <= 1'b1;
      nss_d   <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else begin
      sck_s1  <= spi.sck;
      sck_s2  <= sck_s1;
      sck_d   <= sck_s2;
      nss_s1  <= spi.nss_n;
      nss_s2  <= nss_s1;
      nss_d   <= nss_s2;
      mosi_s1 <= spi.mosi;
      mosi_s2 <= mosi_s1;
    end
  end

  assign rise   = sck_s2 & ~sck_d & ~nss_s2;
  assign fall   = ~sck_s2 & sck_d & ~nss_s2;
  assign fstart = ~nss_s2 & nss_d;
  assign fend   = nss_s2 & ~nss_d;

  always_comb begin
    regs_next  = regs_reg;
    eep_next   = eep_reg;
    list_next  = list_reg;
    shin_next  = shin_reg;
    shout_next = shout_reg;
    bit_next   = bit_reg;
    obit_next  = obit_reg;
    sub_next   = sub_reg;
    pos_next   = pos_reg;
    obyte_next = obyte_reg;
    ent_next   = ent_reg;
    nlist_next = nlist_reg;
    op_next    = op_reg;
    addr_next  = addr_reg;
    act_next   = act_reg;
    ees_next   = ees_reg;
    eel_next   = eel_reg;
    val_next   = val_reg;
    ferr_next  = ferr_reg;
    pend_next  = pend_reg;
    ree_next   = ree_reg;
    ract_next  = ract_reg;
    busy_next  = busy_reg;
    err        = '0;
    b          = {shin_reg[6:0], mosi_s2};
    ea         = 9'({1'b0, ees_reg} + pos_reg - 9'h002);
    if (fstart) begin
      bit_next   = 3'h0;
      obit_next  = 3'h0;
      pos_next   = 9'h000;
      sub_next   = 3'h0;
      ent_next   = 6'h00;
      ferr_next  = 1'b0;
      if (pend_reg) begin
        // a frame while an answer waits is the answer frame
        ract_next  = 1'b1; // R17
        obyte_next = 9'h001;
        shout_next = resp_byte(9'h000);
      end else begin
        ract_next  = 1'b0;
        nlist_next = 5'h00;
        busy_next  = 1'b1; // R18
      end
    end else if (rise) begin
      bit_next  = 3'(bit_reg + 3'h1);
      shin_next = b;
      if (bit_reg == 3'h7 && !ract_reg) begin
        pos_next = 9'(pos_reg + 9'h001);
        if (ferr_reg) begin
          // after an exception the rest of the frame is ignored
        end else if (pos_reg == 9'h000) begin
          op_next = b;
          if (b > OP_RDE) begin
            err[ERR_OP] = 1'b1;
          end
        end else begin
          unique case (op_reg)
            OP_WR, OP_OR, OP_AND: begin
              if (pos_reg == 9'h001) begin
                addr_next = b;
                err[ERR_ADDR] = !addr_ok(b); // R2
              end else if (pos_reg < SINGLE_LEN - 9'h001) begin
                val_next = {b, val_reg[31:8]}; // R1
              end else if (pos_reg == SINGLE_LEN - 9'h001) begin
                regs_next[addr_reg[REG_AW-1:0]] = merge(8'(op_reg + 8'h01),
                  regs_reg[addr_reg[REG_AW-1:0]], {b, val_reg[31:8]}); // R1 R3 R4
              end else begin
                err[ERR_LEN] = 1'b1;
              end
            end
            OP_WRM: begin
              sub_next = (sub_reg == ENT_LAST) ? 3'h0 : 3'(sub_reg + 3'h1);
              if (sub_reg == 3'h0) begin
                addr_next = b;
                err[ERR_LEN] = (ent_reg == WRM_MAX); // R5
                err[ERR_ADDR] = !addr_ok(b); // R2
              end else if (sub_reg == 3'h1) begin
                act_next = b;
                err[ERR_OP] = (b < ACT_WR) || (b > ACT_AND); // R6
              end else if (sub_reg < ENT_LAST) begin
                val_next = {b, val_reg[31:8]};
              end else begin
                // entries are applied as they complete, never rolled back
                regs_next[addr_reg[REG_AW-1:0]] = merge(act_reg,
                  regs_reg[addr_reg[REG_AW-1:0]], {b, val_reg[31:8]}); // R5 R6 R7
                ent_next = 6'(ent_reg + 6'h01);
              end
            end
            OP_RD, OP_RDM: begin
              if (nlist_reg == RDM_MAX || (op_reg == OP_RD && pos_reg != 9'h001)) begin
                err[ERR_LEN] = 1'b1; // R9
              end else begin
                err[ERR_ADDR] = !addr_ok(b); // R2
                list_next[nlist_reg] = b; // R10
                nlist_next = 5'(nlist_reg + 5'h01);
              end
            end
            OP_WRE: begin
              if (pos_reg == 9'h001) begin
                ees_next = b;
                err[ERR_ADDR] = (b > EE_LAST); // R12
              end else if (pos_reg > WRE_LAST_POS) begin
                err[ERR_LEN] = 1'b1; // R12
              end else if (ea > {1'b0, EE_LAST}) begin
                err[ERR_ADDR] = 1'b1;
              end else begin
                eep_next[ea[7:0]] = b; // R11
              end
            end
            default: begin
              if (pos_reg == 9'h001) begin
                ees_next = b;
              end else if (pos_reg == 9'h002) begin
                eel_next = b;
              end else begin
                err[ERR_LEN] = 1'b1;
              end
            end
          endcase
        end
      end
    end else if (fall && ract_reg) begin
      obit_next  = 3'(obit_reg + 3'h1);
      shout_next = {shout_reg[6:0], 1'b0};
      if (obit_reg == 3'h7) begin
        shout_next = resp_byte(obyte_reg);
        obyte_next = 9'(obyte_reg + 9'h001);
      end
    end else if (fend) begin
      ract_next = 1'b0;
      if (ract_reg) begin
        pend_next = 1'b0;
      end else begin
        busy_next = 1'b0; // R18
        if (!ferr_reg && pos_reg != 9'h000) begin
          // only completed OP_WRM entries of the partial instruction have taken effect by now
          unique case (op_reg)
            OP_WR, OP_OR, OP_AND: err[ERR_TRUNC] = (pos_reg < SINGLE_LEN); // R19
            OP_WRM: err[ERR_TRUNC] = (sub_reg != 3'h0) || (ent_reg == 6'h00); // R19
            OP_WRE: err[ERR_TRUNC] = (pos_reg < RDE_LEN); // R12 R19
            OP_RD, OP_RDM: begin
              err[ERR_TRUNC] = (pos_reg < RD_LEN); // R9 R19
              pend_next = (pos_reg >= RD_LEN); // R8 R9
              ree_next  = 1'b0;
            end
            default: begin
              if (pos_reg < RDE_LEN) begin
                err[ERR_TRUNC] = 1'b1; // R19
              end else if (eel_reg == 8'h00) begin
                err[ERR_LEN] = 1'b1;
              end else if (ees_reg > EE_LAST || {1'b0, ees_reg} + {1'b0, eel_reg} > EE_END) begin
                err[ERR_ADDR] = 1'b1; // R14
              end else begin
                pend_next = 1'b1; // R13
                ree_next  = 1'b1;
              end
            end
          endcase
        end
      end
    end
    if (err != '0) begin
      ferr_next = 1'b1;
    end
    // cause bits are ORed after any host write so an event is never lost
    regs_next[IRQ_STAT_ADDR[REG_AW-1:0]][ERR_W-1:0] =
      regs_next[IRQ_STAT_ADDR[REG_AW-1:0]][ERR_W-1:0] | err; // R15
    irq_next = |regs_next[IRQ_STAT_ADDR[REG_AW-1:0]][ERR_W-1:0]; // R15
    exc_next = |err;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_reg[i] <= REG_RESET;
      end
      for (int i = 0; i < EE_SIZE; i++) begin
        eep_reg[i] <= 8'h00;
      end
      for (int i = 0; i < RDM_MAX; i++) begin
        list_reg[i] <= 8'h00;
      end
      shin_reg  <= 8'h00;
      shout_reg <= 8'h00;
      bit_reg   <= 3'h0;
      obit_reg  <= 3'h0;
      sub_reg   <= 3'h0;
      pos_reg   <= 9'h000;
      obyte_reg <= 9'h000;
      ent_reg   <= 6'h00;
      nlist_reg <= 5'h00;
      op_reg    <= 8'h00;
      addr_reg  <= 8'h00;
      act_reg   <= 8'h00;
      ees_reg   <= 8'h00;
      eel_reg   <= 8'h00;
      val_reg   <= 32'h0000_0000;
      ferr_reg  <= 1'b0;
      pend_reg  <= 1'b0;
      ree_reg   <= 1'b0;
      ract_reg  <= 1'b0;
      busy_reg  <= 1'b0;
      irq_reg   <= 1'b0;
      exc_reg   <= 1'b0;
    end else begin
      regs_reg  <= regs_next;
      eep_reg   <= eep_next;
      list_reg  <= list_next;
      shin_reg  <= shin_next;
      shout_reg <= shout_next;
      bit_reg   <= bit_next;
      obit_reg  <= obit_next;
      sub_reg   <= sub_next;
      pos_reg   <= pos_next;
      obyte_reg <= obyte_next;
      ent_reg   <= ent_next;
      nlist_reg <= nlist_next;
      op_reg    <= op_next;
      addr_reg  <= addr_next;
      act_reg   <= act_next;
      ees_reg   <= ees_next;
      eel_reg   <= eel_next;
      val_reg   <= val_next;
      ferr_reg  <= ferr_next;
      pend_reg  <= pend_next;
      ree_reg   <= ree_next;
      ract_reg  <= ract_next;
      busy_reg  <= busy_next;
      irq_reg   <= irq_next;
      exc_reg   <= exc_next;
    end
  end

  assign spi.miso  = shout_reg[7];
  assign spi.busy  = busy_reg;
  assign spi.irq   = irq_reg;
  assign exc_pulse = exc_reg;
  assign cfg0      = regs_reg[0];
endmodule

// *** hrc_pkg.sv ***
// package: opcodes, limits and timing of the host command decoder
// Notes on behaviour
// R1 - store: opcode, address, four bytes LSB first
// R2 - unknown register address raises exception
// R3 - or-mask: read, OR, write back
// R4 - and-mask: read, AND, write back
// R5 - batch: up to 42 six-byte entries
// R6 - each batch entry applies its own action
// R7 - batch exception keeps earlier writes
// R8 - single read returns four bytes
// R9 - batch read takes 1 to 18 addresses
// R10 - batch read answers values in request order
// R11 - nvm store writes consecutive bytes, no answer
// R12 - nvm store: start 0-254, count 1-255
// R13 - nvm read returns bytes upward from start
// R14 - nvm read must not pass 254
// R15 - exception sets irq and cause bits
// R16 - host keeps select low whole instruction
// R17 - write one frame, read two frames
// R18 - busy low means answer readable
// R19 - short instruction discarded and raises exception
package hrc_pkg;
  localparam logic [7:0] OP_WR   = 8'h00;
  localparam logic [7:0] OP_OR   = 8'h01;
  localparam logic [7:0] OP_AND  = 8'h02;
  localparam logic [7:0] OP_WRM  = 8'h03;
  localparam logic [7:0] OP_RD   = 8'h04;
  localparam logic [7:0] OP_RDM  = 8'h05;
  localparam logic [7:0] OP_WRE  = 8'h06;
  localparam logic [7:0] OP_RDE  = 8'h07;
  localparam logic [7:0] ACT_WR  = 8'h01;
  localparam logic [7:0] ACT_OR  = 8'h02;
  localparam logic [7:0] ACT_AND = 8'h03;
  // register file: addresses 0x00..0x1f exist
  localparam int         REG_COUNT     = 32;
  localparam int         REG_AW        = 5;
  localparam logic [7:0] REG_LIMIT     = 8'h20;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h02;
  localparam logic [31:0] REG_RESET    = 32'h0000_0000;
  // cause bits in the interrupt status register
  localparam int         ERR_W     = 4;
  localparam int         ERR_ADDR  = 0;
  localparam int         ERR_LEN   = 1;
  localparam int         ERR_TRUNC = 2;
  localparam int         ERR_OP    = 3;
  // lengths and limits
  localparam logic [5:0] WRM_MAX      = 6'h2a;
  localparam logic [2:0] ENT_LAST     = 3'h5;
  localparam logic [4:0] RDM_MAX      = 5'h12;
  localparam logic [8:0] SINGLE_LEN   = 9'h006;
  localparam logic [8:0] RD_LEN       = 9'h002;
  localparam logic [8:0] RDE_LEN      = 9'h003;
  localparam logic [8:0] WRE_LAST_POS = 9'h100;
  localparam logic [7:0] EE_LAST      = 8'hfe;
  localparam logic [8:0] EE_END       = 9'h0ff;
  localparam int         EE_SIZE      = 255;
  // timing of the host-made serial clock
  localparam int         MCLK_PERIOD_NS = 50;
  localparam int         SCK_PERIOD_NS  = 800;
  localparam int         SCK_HALF_CYC   = SCK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
  localparam int         TIM_W          = 4;
endpackage

// *** hrc_spi_if.sv ***
// interface: serial host link between controller and decoder
`timescale 1ns/100ps
interface hrc_spi_if;
  logic sck;
  logic nss_n;
  logic mosi;
  logic miso;
  logic busy;
  logic irq;
  modport dev (
    input  sck,
    input  nss_n,
    input  mosi,
    output miso,
    output busy,
    output irq
  );
  modport host (
    output sck,
    output nss_n,
    output mosi,
    input  miso,
    input  busy,
    input  irq
  );
endinterface

// *** hrc_host.sv ***
// host end: sends instruction frames and clocks out answer frames
`timescale 1ns/100ps
module hrc_host
  import hrc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  hrc_spi_if.host          spi,
  input  wire logic        start,
  input  wire logic [8:0]  tx_len,
  input  wire logic [8:0]  rx_len,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic [7:0]       rx_data,
  output logic             rx_valid,
  output logic             done,
  output logic             idle,
  output logic             irq_out
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LEAD = 3'b001,
    H_LOW  = 3'b011,
    H_HIGH = 3'b010,
    H_TAIL = 3'b110,
    H_GAP  = 3'b111,
    H_WAIT = 3'b101
  } hrc_hst_t;

  localparam logic [TIM_W-1:0] HALF_M1 = TIM_W'(SCK_HALF_CYC - 1);

  hrc_hst_t          st_reg, st_next;
  logic [TIM_W-1:0]  tim_reg, tim_next;
  logic [8:0]        cnt_reg, cnt_next, rxn_reg, rxn_next;
  logic [2:0]        bit_reg, bit_next;
  logic [7:0]        sh_reg, sh_next, rsh_reg, rsh_next, rxd_reg, rxd_next;
  logic              ph_reg, ph_next, sck_reg, sck_next, nss_reg, nss_next;
  logic              rxv_reg, rxv_next, done_reg, done_next;
  logic              miso_s1, miso_s2, busy_s1, busy_s2, irq_s1, irq_s2;
  logic              half;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
      busy_s1 <= 1'b1;
      busy_s2 <= 1'b1;
      irq_s1  <= 1'b0;
      irq_s2  <= 1'b0;
    end else begin
      miso_s1 <= spi.miso;
      miso_s2 <= miso_s1;
      busy_s1 <= spi.busy;
      busy_s2 <= busy_s1;
      irq_s1  <= spi.irq;
      irq_s2  <= irq_s1;
    end
  end

  assign half     = (tim_reg == HALF_M1);
  assign tx_ready = (st_reg == H_LEAD) && half && !ph_reg;
  assign idle     = (st_reg == H_IDLE);

  always_comb begin
    st_next   = st_reg;
    tim_next  = TIM_W'(tim_reg + 1'b1);
    cnt_next  = cnt_reg;
    rxn_next  = rxn_reg;
    bit_next  = bit_reg;
    sh_next   = sh_reg;
    rsh_next  = rsh_reg;
    rxd_next  = rxd_reg;
    ph_next   = ph_reg;
    sck_next  = sck_reg;
    nss_next  = nss_reg;
    rxv_next  = 1'b0;
    done_next = 1'b0;
    unique case (st_reg)
      H_IDLE: begin
        tim_next = '0;
        if (start && tx_len != 9'h000) begin
          cnt_next = tx_len;
          rxn_next = rx_len;
          ph_next  = 1'b0;
          nss_next = 1'b0; // R16
          st_next  = H_LEAD;
        end
      end
      H_LEAD: begin
        if (!half) begin
        end else if (ph_reg) begin
          sh_next  = 8'h00;
          tim_next = '0;
          bit_next = 3'h0;
          st_next  = H_LOW;
        end else if (tx_valid) begin
          sh_next  = tx_data;
          tim_next = '0;
          bit_next = 3'h0;
          st_next  = H_LOW;
        end else begin
          // stall with select held low, the frame stays whole
          tim_next = tim_reg; // R16
        end
      end
      H_LOW: begin
        if (half) begin
          sck_next = 1'b1;
          rsh_next = {rsh_reg[6:0], miso_s2};
          tim_next = '0;
          st_next  = H_HIGH;
        end
      end
      H_HIGH: begin
        if (half) begin
          sck_next = 1'b0;
          tim_next = '0;
          bit_next = 3'(bit_reg + 3'h1);
          sh_next  = {sh_reg[6:0], 1'b0};
          st_next  = H_LOW;
          if (bit_reg == 3'h7) begin
            rxd_next = rsh_reg;
            rxv_next = ph_reg;
            cnt_next = 9'(cnt_reg - 9'h001);
            st_next  = (cnt_reg == 9'h001) ? H_TAIL : H_LEAD;
          end
        end
      end
      H_TAIL: begin
        if (half) begin
          nss_next = 1'b1; // R17
          tim_next = '0;
          st_next  = H_GAP;
        end
      end
      H_GAP: begin
        if (half) begin
          tim_next = '0;
          if (!ph_reg && rxn_reg != 9'h000) begin
            ph_next  = 1'b1; // R17
            cnt_next = rxn_reg;
            st_next  = H_WAIT;
          end else begin
            done_next = 1'b1;
            st_next   = H_IDLE;
          end
        end
      end
      H_WAIT: begin
        tim_next = '0;
        if (!busy_s2) begin
          nss_next = 1'b0; // R18
          st_next  = H_LEAD;
        end
      end
      default: begin
        nss_next = 1'b1;
        sck_next = 1'b0;
        st_next  = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg   <= H_IDLE;
      tim_reg  <= '0;
      cnt_reg  <= 9'h000;
      rxn_reg  <= 9'h000;
      bit_reg  <= 3'h0;
      sh_reg   <= 8'h00;
      rsh_reg  <= 8'h00;
      rxd_reg  <= 8'h00;
      ph_reg   <= 1'b0;
      sck_reg  <= 1'b0;
      nss_reg  <= 1'b1;
      rxv_reg  <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      tim_reg  <= tim_next;
      cnt_reg  <= cnt_next;
      rxn_reg  <= rxn_next;
      bit_reg  <= bit_next;
      sh_reg   <= sh_next;
      rsh_reg  <= rsh_next;
      rxd_reg  <= rxd_next;
      ph_reg   <= ph_next;
      sck_reg  <= sck_next;
      nss_reg  <= nss_next;
      rxv_reg  <= rxv_next;
      done_reg <= done_next;
    end
  end

  assign spi.sck   = sck_reg;
  assign spi.nss_n = nss_reg;
  assign spi.mosi  = sh_reg[7];
  assign rx_data   = rxd_reg;
  assign rx_valid  = rxv_reg;
  assign done      = done_reg;
  assign irq_out   = irq_s2;
endmodule

// *** hrc_asserts.sv ***
// checker: timing and event properties of the serial host link
`timescale 1ns/100ps
module hrc_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sck,
  input wire logic nss_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic busy,
  input wire logic irq,
  input wire logic exc_pulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sck_idle_a: assert property (nss_n |-> !sck)
    else $error("sck high outside frame");
  frame_hold_a: assert property ($fell(nss_n) |-> !nss_n [*8])
    else $error("frame select too short");
  sck_high_a: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
    else $error("sck high phase not eight cycles");
  mosi_hold_a: assert property (sck |-> $stable(mosi))
    else $error("mosi moved while sck high");
  exc_irq_a: assert property (exc_pulse |-> ##[0:2] irq)
    else $error("exception without irq");
  irq_clear_a: assert property ($fell(irq) |-> !nss_n)
    else $error("irq dropped outside a frame");
  busy_fall_a: assert property ($fell(busy) |-> nss_n)
    else $error("busy dropped inside a frame");
  frame_start_a: assert property ($fell(nss_n) |-> !busy)
    else $error("frame started while busy");
  cover property ($rose(irq));
  cover property ($fell(busy));
  cover property ($rose(nss_n) && !busy);
endmodule

// *** host_register_eeprom_commands_bench.sv ***
// bench: both link ends joined, driven through the host user port
`timescale 1ns/100ps
`define CK(n,e,g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module host_register_eeprom_commands_bench
  import hrc_pkg::*;
;
  logic        mclk, rst, start, tx_valid, tx_ready, rx_valid, done, idle;
  logic        irq_out, exc_pulse;
  logic [8:0]  tx_len, rx_len;
  logic [7:0]  tx_data, rx_data, act;
  logic [31:0] cfg0, v;
  logic [31:0] m [REG_COUNT];
  logic [7:0]  ee [EE_SIZE];
  logic [7:0]  q [$];
  logic [7:0]  r [$];
  int          al [18];
  int          num_errors, comparisons, i, j, k, a, e0;
  int          nexc = 0;
  hrc_spi_if spi ();
  hrc_dev hrc_dev_inst (.mclk(mclk), .rst(rst), .spi(spi), .exc_pulse(exc_pulse), .cfg0(cfg0));
  hrc_host hrc_host_inst (.mclk(mclk), .rst(rst), .spi(spi), .start(start), .tx_len(tx_len),
    .rx_len(rx_len), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .done(done), .idle(idle), .irq_out(irq_out));
  hrc_asserts hrc_asserts_inst (.mclk(mclk), .rst(rst), .sck(spi.sck), .nss_n(spi.nss_n),
    .mosi(spi.mosi), .miso(spi.miso), .busy(spi.busy), .irq(spi.irq), .exc_pulse(exc_pulse));
  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) if (exc_pulse === 1'b1) nexc <= nexc + 1;
  task print_verdict;
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // sends q as one request, collects rl answer bytes into r
  task automatic xfer(input int rl);
    int n, p;
    r = {};
    p = 0;
    @(posedge mclk);
    tx_len <= 9'(q.size());
    rx_len <= 9'(rl);
    tx_data <= q[0];
    tx_valid <= 1;
    start <= 1;
    @(posedge mclk);
    start <= 0;
    for (n = 0; n < 50000; n++) begin
      @(negedge mclk);
      if (rx_valid === 1'b1) r.push_back(rx_data);
      if (done === 1'b1) break;
      if (tx_ready === 1'b1) begin
        @(posedge mclk);
        p++;
        tx_data <= (p < q.size()) ? q[p] : 8'h00;
      end
    end
    if (n == 50000) begin
      num_errors++;
      print_verdict;
    end
    `CK("idle", 1'b1, idle)
  endtask
  task automatic wr(input logic [7:0] op, input logic [7:0] ad, input logic [31:0] d);
    q = {op, ad, d[7:0], d[15:8], d[23:16], d[31:24]};
    xfer(0);
  endtask
  task automatic rd(input logic [7:0] ad);
    q = {OP_RD, ad};
    xfer(4);
  endtask
  function automatic logic [31:0] w(input int x);
    return {r[4*x+3], r[4*x+2], r[4*x+1], r[4*x]};
  endfunction
  function automatic logic [31:0] f(input logic [7:0] c, input logic [31:0] o, d);
    case (c)
      ACT_OR:  return o | d;
      ACT_AND: return o & d;
      default: return d;
    endcase
  endfunction
  // one new exception of cause b (b < 0: cause not checked), then cleared
  task automatic exc_chk(input int b);
    `CK("exc_count", e0 + 1, nexc)
    `CK("irq", 1'b1, irq_out)
    rd(IRQ_STAT_ADDR);
    if (b >= 0) `CK("cause", 1'b1, r[0][b])
    wr(OP_WR, IRQ_STAT_ADDR, 32'h0000_0000);
    `CK("irq_clear", 1'b0, irq_out)
  endtask
  initial begin
    rst = 1;
    start = 0;
    tx_len = 0;
    rx_len = 0;
    tx_data = 0;
    tx_valid = 0;
    a = $urandom(33506);
    for (i = 0; i < REG_COUNT; i++) m[i] = REG_RESET;
    for (i = 0; i < EE_SIZE; i++) ee[i] = 8'h00;
    repeat (5) @(posedge mclk);
    rst <= 0;
    for (k = 0; k < 6; k++) begin
      a = (k == 0) ? 0 : 3 + $urandom % 29;
      m[a] = $urandom;
      wr(OP_WR, 8'(a), m[a]);
      rd(8'(a));
      `CK("read", m[a], w(0))
    end
    `CK("cfg0", m[0], cfg0)
    for (k = 1; k < 3; k++) begin
      v = $urandom;
      m[0] = f(8'(k + 1), m[0], v);
      wr(8'(k), 8'h00, v);
      `CK("mask", m[0], cfg0)
    end
    q = {OP_WRM};
    for (k = 0; k < 6; k++) begin
      a = 3 + $urandom % 29;
      v = $urandom;
      act = 8'(k % 3 + 1);
      m[a] = f(act, m[a], v);
      q = {q, 8'(a), act, v[7:0], v[15:8], v[23:16], v[31:24]};
    end
    xfer(0);
    q = {OP_RDM};
    for (k = 0; k < 18; k++) begin
      al[k] = (k == 0) ? 0 : 3 + $urandom % 29;
      q.push_back(8'(al[k]));
    end
    xfer(72);
    `CK("rdm_len", 72, r.size())
    for (k = 0; k < 18; k++) `CK("rdm", m[al[k]], w(k))
    e0 = nexc;
    v = $urandom;
    m[5] = v;
    q = {OP_WRM, 8'h05, ACT_WR, v[7:0], v[15:8], v[23:16], v[31:24], REG_LIMIT, ACT_WR};
    q = {q, v[7:0], v[15:8], v[23:16], v[31:24]};
    xfer(0);
    exc_chk(ERR_ADDR);
    rd(8'h05);
    `CK("kept", m[5], w(0))
    e0 = nexc;
    q = {OP_RDM};
    repeat (19) q.push_back(8'h03);
    xfer(0);
    exc_chk(ERR_LEN);
    e0 = nexc;
    q = {OP_WR, 8'h00, 8'hff};
    xfer(0);
    exc_chk(ERR_TRUNC);
    `CK("trunc", m[0], cfg0)
    e0 = nexc;
    q = {8'h08, 8'h00};
    xfer(0);
    exc_chk(ERR_OP);
    e0 = nexc;
    q = {OP_WRM, 8'h03, 8'h04};
    xfer(0);
    exc_chk(ERR_OP);
    e0 = nexc;
    q = {OP_WRE, 8'h10};
    xfer(0);
    exc_chk(ERR_TRUNC);
    for (j = 0; j < 2; j++) begin
      a = j * 251;
      q = {OP_WRE, 8'(a)};
      for (k = 0; k < 4; k++) begin
        ee[a+k] = 8'($urandom);
        q.push_back(ee[a+k]);
      end
      xfer(0);
      q = {OP_RDE, 8'(a), 8'h04};
      xfer(4);
      for (k = 0; k < 4; k++) `CK("nvm", ee[a+k], r[k])
    end
    e0 = nexc;
    ee[254] = 8'($urandom);
    q = {OP_WRE, EE_LAST, ee[254], 8'h5a};
    xfer(0);
    exc_chk(ERR_ADDR);
    q = {OP_RDE, EE_LAST, 8'h01};
    xfer(1);
    `CK("nvm_end", ee[254], r[0])
    e0 = nexc;
    q = {OP_WRE, 8'hff, 8'h00};
    xfer(0);
    exc_chk(-1);
    e0 = nexc;
    q = {OP_RDE, 8'hfd, 8'h03};
    xfer(0);
    exc_chk(-1);
    print_verdict;
  end
endmodule
